// [hdl/event_latch.sv]
module event_latch (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_level,
  input  wire logic i_clear,
  output logic      o_flag
);

  logic level_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= i_level;
    end
  end

  // rising edge sets; set beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_level && !level_reg) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end

endmodule

// [hdl/id_detect_pkg.sv]
package id_detect_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  // debounce of the enable pin, in milliseconds
  localparam int unsigned DEBOUNCE_MS = 100;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;

  localparam logic [7:0] ADDR_IDENTITY  = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h01;
  localparam logic [7:0] ADDR_STATUS    = 8'h02;
  localparam logic [7:0] ADDR_LATCHES   = 8'h03;
  localparam logic [7:0] ADDR_MASK      = 8'h04;
  localparam logic [7:0] ADDR_SRC_THR   = 8'h06;
  localparam logic [7:0] ADDR_SRC_TMR   = 8'h07;
  localparam logic [7:0] ADDR_CTRL_TWO  = 8'h08;
  localparam logic [7:0] ADDR_PASS_FET  = 8'h09;
  localparam logic [7:0] ADDR_ACC_THR   = 8'h0a;
  localparam logic [7:0] ADDR_RESULT    = 8'h0b;
  localparam logic [7:0] ADDR_FM_CUR    = 8'h0d;
  localparam logic [7:0] ADDR_FM_HI     = 8'h0e;
  localparam logic [7:0] ADDR_FM_LO     = 8'h0f;

  localparam logic [7:0] RST_CTRL_ONE = 8'h6a;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  localparam logic [7:0] RST_MASK     = 8'hff;
  localparam logic [7:0] RST_SRC_THR  = 8'h03;
  localparam logic [7:0] RST_SRC_TMR  = 8'h13;
  localparam logic [7:0] RST_CTRL_TWO = 8'h0c;
  localparam logic [7:0] RST_ACC_THR  = 8'h6e;
  localparam logic [7:0] RST_FM_CUR   = 8'h02;
  localparam logic [7:0] RST_FM_HI    = 8'haf;
  localparam logic [7:0] RST_FM_LO    = 8'h82;

  // control one fields
  localparam int unsigned C1_SRC_EN     = 6;
  localparam int unsigned C1_ZC_CHECK   = 5;
  localparam int unsigned C1_FM_OFF     = 1;
  localparam int unsigned C1_SLEEP      = 0;
  localparam logic [7:0]  C1_WR_MASK    = 8'h63;

  // status, latch and mask bit positions (shared layout)
  localparam int unsigned B_BIAS   = 7;
  localparam int unsigned B_ZC     = 6;
  localparam int unsigned B_CONV   = 5;
  localparam int unsigned B_TIMER  = 4;
  localparam int unsigned B_ACC    = 3;
  localparam int unsigned B_THERM  = 2;
  localparam int unsigned B_OVLO   = 1;
  localparam int unsigned B_ENPIN  = 0;

  // pass-fet control fields
  localparam int unsigned PF_READY  = 3;
  localparam int unsigned PF_ENABLE = 1;
  localparam int unsigned PF_MANUAL = 0;
  localparam logic [7:0]  PF_WR_MASK = 8'h03;

  localparam logic [7:0]  SRC_THR_WR_MASK = 8'h07;
  localparam logic [7:0]  SRC_TMR_WR_MASK = 8'h3f;
  localparam logic [7:0]  CTRL_TWO_WR_MASK = 8'h0f;
  localparam logic [7:0]  FM_CUR_WR_MASK  = 8'h07;

  // analog front-end indications, sampled each clock
  typedef struct packed {
    logic       bias_present;
    logic       zero_cross_seen;
    logic       conv_done;
    logic       period_timer_expired;
    logic       accessory;
    logic       thermal;
    logic       id_overvoltage;
    logic       fm_ready;
    logic [7:0] conv_result;
  } analog_in_t;

  // register port as seen from the serial interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [hdl/id_detector_status_regs.sv]
// Notes on behaviour
// - conversion-done status is one if a new result arrived since last read.
// - zero-cross status reports a crossing; valid only with check enable set.
// - factory mode: bias status is one while ID is above the bias threshold.
// - timer status is one once the programmed period has expired.
// - overvoltage status is one while the ID pin is in overvoltage.
// - enable-pin status is one when the active-low pin is low.
// - bias rise latches an event bit; reading the latch register clears them.
// - zero-cross event sets its latch, held until the latch register is read.
// - end of conversion sets its latch, held until the latch register is read.
// - with the manual bit clear, factory mode drives the open-drain pass-fet output when ready and biased.
// - active only with pin low and sleep clear; detect after 100 ms debounce.
// - shutdown returns every register to its default; control one only while the pin is high, not on sleep.
// - a mask bit of one keeps its latched event off the interrupt pin; zero lets it through.
module id_detector_status_regs
  import id_detect_pkg::*;
#(
  parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYCLES,
  parameter logic [7:0]  IDENTITY     = 8'h5a  // arbitrary value
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_enable_n,
  input  wire id_detect_pkg::analog_in_t i_analog,
  input  wire id_detect_pkg::reg_req_t i_req,
  output logic [7:0]                   o_rdata,
  output logic                         o_int_n_oe,
  output logic                         o_int_n_out,
  output logic                         o_pass_fet_drive_oe,
  output logic                         o_pass_fet_drive_out,
  output logic                         o_detect_active,
  output logic                         o_shutdown
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  ctrl_one_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  src_thr_reg;
  logic [7:0]  src_tmr_reg;
  logic [7:0]  ctrl_two_reg;
  logic [7:0]  pass_fet_reg;
  logic [7:0]  acc_thr_reg;
  logic [7:0]  result_reg;
  logic [7:0]  fm_cur_reg;
  logic [7:0]  fm_hi_reg;
  logic [7:0]  fm_lo_reg;
  logic        conv_pending_reg;
  logic [31:0] debounce_reg;
  logic        debounced_reg;
  logic [7:0]  live_status;
  logic [7:0]  latches;
  logic [7:0]  sources;
  logic        shutdown;
  logic        factory_mode;
  logic        rd_status;
  logic        rd_latches;
  logic        clr_rst;

  ////////////////////////////////////////////////////////////////////////////
  // shutdown: pin high or sleep requested
  assign shutdown = i_enable_n || ctrl_one_reg[C1_SLEEP];
  // registers fall back to defaults for as long as the part is shut down
  assign clr_rst  = i_rst || shutdown;
  assign o_shutdown = shutdown;

  assign factory_mode = !ctrl_one_reg[C1_FM_OFF] && !shutdown;
  assign rd_status  = i_req.rd && (i_req.addr == ADDR_STATUS);
  assign rd_latches = i_req.rd && (i_req.addr == ADDR_LATCHES);

  ////////////////////////////////////////////////////////////////////////////
  // enable pin debounce
  always_ff @(posedge i_clk) begin
    if (i_rst || i_enable_n) begin
      debounce_reg  <= '0;
      debounced_reg <= 1'b0;
    end else if (debounce_reg >= DEBOUNCE_LEN - 1) begin
      debounced_reg <= 1'b1;
    end else begin
      debounce_reg <= debounce_reg + 32'h0000_0001;
    end
  end

  // gated by the live pin too, so a pin release drops detection at once
  assign o_detect_active = debounced_reg && !shutdown;

  ////////////////////////////////////////////////////////////////////////////
  // writable registers; the sleep bit itself survives the shutdown it causes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_one_reg <= RST_CTRL_ONE;
    end else if (i_req.wr && i_req.addr == ADDR_CTRL_ONE) begin
      ctrl_one_reg <= i_req.wdata & C1_WR_MASK;
    end else if (i_enable_n) begin
      ctrl_one_reg <= RST_CTRL_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (clr_rst) begin
      mask_reg     <= RST_MASK;
      src_thr_reg  <= RST_SRC_THR;
      src_tmr_reg  <= RST_SRC_TMR;
      ctrl_two_reg <= RST_CTRL_TWO;
      pass_fet_reg <= RST_ZERO;
      acc_thr_reg  <= RST_ACC_THR;
      fm_cur_reg   <= RST_FM_CUR;
      fm_hi_reg    <= RST_FM_HI;
      fm_lo_reg    <= RST_FM_LO;
    end else if (i_req.wr) begin
      if (i_req.addr == ADDR_MASK) begin
        mask_reg <= i_req.wdata;
      end else if (i_req.addr == ADDR_SRC_THR) begin
        src_thr_reg <= i_req.wdata & SRC_THR_WR_MASK;
      end else if (i_req.addr == ADDR_SRC_TMR) begin
        src_tmr_reg <= i_req.wdata & SRC_TMR_WR_MASK;
      end else if (i_req.addr == ADDR_CTRL_TWO) begin
        ctrl_two_reg <= i_req.wdata & CTRL_TWO_WR_MASK;
      end else if (i_req.addr == ADDR_PASS_FET) begin
        pass_fet_reg <= i_req.wdata & PF_WR_MASK;
      end else if (i_req.addr == ADDR_ACC_THR) begin
        acc_thr_reg <= i_req.wdata;
      end else if (i_req.addr == ADDR_FM_CUR) begin
        fm_cur_reg <= i_req.wdata & FM_CUR_WR_MASK;
      end else if (i_req.addr == ADDR_FM_HI) begin
        fm_hi_reg <= i_req.wdata;
      end else if (i_req.addr == ADDR_FM_LO) begin
        fm_lo_reg <= i_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion result and its pending flag
  always_ff @(posedge i_clk) begin
    if (clr_rst) begin
      result_reg <= RST_ZERO;
    end else if (i_analog.conv_done) begin
      result_reg <= i_analog.conv_result;
    end
  end

  // a new conversion in the read cycle stays pending
  always_ff @(posedge i_clk) begin
    if (clr_rst) begin
      conv_pending_reg <= 1'b0;
    end else if (i_analog.conv_done) begin
      conv_pending_reg <= 1'b1;
    end else if (rd_status) begin
      conv_pending_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live status
  always_comb begin
    live_status          = 8'h00;
    live_status[B_BIAS]  = factory_mode && i_analog.bias_present;
    // only reported while the check is enabled
    live_status[B_ZC]    = ctrl_one_reg[C1_ZC_CHECK]
                           && i_analog.zero_cross_seen;
    live_status[B_CONV]  = conv_pending_reg;
    live_status[B_TIMER] = i_analog.period_timer_expired;
    live_status[B_ACC]   = i_analog.accessory;
    live_status[B_THERM] = i_analog.thermal;
    live_status[B_OVLO]  = i_analog.id_overvoltage;
    live_status[B_ENPIN] = !i_enable_n;
  end

  // latch sources: levels whose rising edge is an event
  always_comb begin
    sources          = live_status;
    sources[B_CONV]  = i_analog.conv_done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // event latches, cleared by reading the latch register
  for (genvar g = 0; g < 8; g++) begin : g_latch
    event_latch u_latch (
      .i_clk   (i_clk),
      .i_rst   (clr_rst),
      .i_level (sources[g]),
      .i_clear (rd_latches),
      .o_flag  (latches[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin: open drain, driven low while any unmasked latch is set
  assign o_int_n_out = 1'b0;
  assign o_int_n_oe  = |(latches & ~mask_reg);

  // pass-fet: manual bit selects software control, else factory readiness
  always_ff @(posedge i_clk) begin
    if (clr_rst) begin
      o_pass_fet_drive_oe <= 1'b0;
    end else if (pass_fet_reg[PF_MANUAL]) begin
      o_pass_fet_drive_oe <= pass_fet_reg[PF_ENABLE];
    end else begin
      o_pass_fet_drive_oe <= factory_mode && i_analog.fm_ready
                             && i_analog.bias_present;
    end
  end
  assign o_pass_fet_drive_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // read data, registered
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= RST_ZERO;
    end else if (i_req.rd) begin
      if (i_req.addr == ADDR_IDENTITY) begin
        o_rdata <= IDENTITY;
      end else if (i_req.addr == ADDR_CTRL_ONE) begin
        o_rdata <= ctrl_one_reg;
      end else if (i_req.addr == ADDR_STATUS) begin
        o_rdata <= live_status;
      end else if (i_req.addr == ADDR_LATCHES) begin
        o_rdata <= latches;
      end else if (i_req.addr == ADDR_MASK) begin
        o_rdata <= mask_reg;
      end else if (i_req.addr == ADDR_SRC_THR) begin
        o_rdata <= src_thr_reg;
      end else if (i_req.addr == ADDR_SRC_TMR) begin
        o_rdata <= src_tmr_reg;
      end else if (i_req.addr == ADDR_CTRL_TWO) begin
        o_rdata <= ctrl_two_reg;
      end else if (i_req.addr == ADDR_PASS_FET) begin
        o_rdata <= pass_fet_reg | ({7'h00, i_analog.fm_ready} << PF_READY);
      end else if (i_req.addr == ADDR_ACC_THR) begin
        o_rdata <= acc_thr_reg;
      end else if (i_req.addr == ADDR_RESULT) begin
        o_rdata <= result_reg;
      end else if (i_req.addr == ADDR_FM_CUR) begin
        o_rdata <= fm_cur_reg;
      end else if (i_req.addr == ADDR_FM_HI) begin
        o_rdata <= fm_hi_reg;
      end else if (i_req.addr == ADDR_FM_LO) begin
        o_rdata <= fm_lo_reg;
      end else begin
        o_rdata <= RST_ZERO;
      end
    end
  end

endmodule

// [sim/host_model.sv]
module host_model (
  input  wire logic              i_clk,
  input  wire logic [7:0]        i_rdata,
  output id_detect_pkg::reg_req_t o_req,
  output logic                   o_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import id_detect_pkg::*;
  initial begin
    o_req = '0;
    o_enable_n = 1'b1;
  end
  // released address and data are inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clk);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clk);
    d = i_rdata;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask
  task automatic pin(input logic v);
    @(negedge i_clk);
    o_enable_n = v;
  endtask
endmodule

// [sim/id_regs_asserts.sv]
module id_regs_checker
#(
  parameter int unsigned DEBOUNCE_LEN = 20
) (
  input wire logic                     i_clk,
  input wire logic                     i_rst,
  input wire logic                     i_enable_n,
  input wire id_detect_pkg::analog_in_t i_analog,
  input wire id_detect_pkg::reg_req_t  i_req,
  input wire logic [7:0]               o_rdata,
  input wire logic                     o_int_n_oe,
  input wire logic                     o_int_n_out,
  input wire logic                     o_pass_fet_drive_oe,
  input wire logic                     o_pass_fet_drive_out,
  input wire logic                     o_detect_active,
  input wire logic                     o_shutdown
);
  import id_detect_pkg::*;
  // cycles the pin has been low, saturating at the debounce length
  int unsigned low_cnt;
  always_ff @(posedge i_clk) begin
    if (i_rst || i_enable_n) begin
      low_cnt <= 0;
    end else if (low_cnt < DEBOUNCE_LEN) begin
      low_cnt <= low_cnt + 1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////
  a_pin_shutdown: assert property (i_enable_n |-> o_shutdown)
    else $error("no shutdown while enable pin high");
  a_idle_in_shut: assert property (o_shutdown |-> !o_detect_active)
    else $error("detection active during shutdown");
  a_debounce_len: assert property (
    o_detect_active |-> low_cnt >= DEBOUNCE_LEN - 1)
    else $error("detection started before debounce ran out");
  a_int_quiet_shut: assert property (
    o_shutdown ##1 o_shutdown |-> !o_int_n_oe)
    else $error("interrupt pin low in shutdown");
  a_read_clears: assert property (
    i_req.rd && i_req.addr == ADDR_LATCHES && $stable(i_analog)
      && !i_analog.conv_done && $stable(i_enable_n)
      && !$past(i_req.wr) |=> !o_int_n_oe)
    else $error("interrupt stays after latch read");
  a_open_drain: assert property (
    !o_int_n_out && !o_pass_fet_drive_out)
    else $error("open drain output driven high");
  a_pf_manual_on: assert property (
    i_req.wr && i_req.addr == ADDR_PASS_FET && i_req.wdata[1:0] == 2'b11
      && !o_shutdown ##1 !o_shutdown |-> ##[0:1] o_pass_fet_drive_oe)
    else $error("pass fet not driven in manual mode");
  a_status_pin: assert property (
    i_req.rd && i_req.addr == ADDR_STATUS && !o_shutdown
      && $stable(i_enable_n) |=> o_rdata[B_ENPIN])
    else $error("enable pin status not set");
  a_status_ovlo: assert property (
    i_req.rd && i_req.addr == ADDR_STATUS && !o_shutdown
      && $stable(i_analog.id_overvoltage)
      |=> o_rdata[B_OVLO] == $past(i_analog.id_overvoltage))
    else $error("overvoltage status wrong");
  c_int_seen: cover property ($rose(o_int_n_oe));
  c_active: cover property ($rose(o_detect_active));
  c_pf_on: cover property ($rose(o_pass_fet_drive_oe));
endmodule
bind id_detector_status_regs id_regs_checker #(
  .DEBOUNCE_LEN(DEBOUNCE_LEN)
) i_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_enable_n(i_enable_n),
  .i_analog(i_analog), .i_req(i_req), .o_rdata(o_rdata),
  .o_int_n_oe(o_int_n_oe), .o_int_n_out(o_int_n_out),
  .o_pass_fet_drive_oe(o_pass_fet_drive_oe),
  .o_pass_fet_drive_out(o_pass_fet_drive_out),
  .o_detect_active(o_detect_active), .o_shutdown(o_shutdown)
);

// [sim/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import id_detect_pkg::*;
  localparam int unsigned DEB = 20;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic enable_n;
  analog_in_t analog = '0;
  reg_req_t req;
  logic [7:0] rdata;
  logic int_oe, int_out, pf_oe, pf_out, active, shut;
  int err_count = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  id_detector_status_regs #(.DEBOUNCE_LEN(DEB), .IDENTITY(ID_VAL))
    i_id_detector_status_regs (
    .i_clk(clk), .i_rst(rst), .i_enable_n(enable_n), .i_analog(analog),
    .i_req(req), .o_rdata(rdata), .o_int_n_oe(int_oe),
    .o_int_n_out(int_out), .o_pass_fet_drive_oe(pf_oe),
    .o_pass_fet_drive_out(pf_out), .o_detect_active(active),
    .o_shutdown(shut));
  host_model i_host_model (.i_clk(clk), .i_rdata(rdata), .o_req(req),
    .o_enable_n(enable_n));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host_model.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_shut_hold;
    i_host_model.wr(ADDR_MASK, 8'h00);
    chk("shutdown", {7'h00, shut}, 8'h01);
    rc(ADDR_MASK, RST_MASK);
  endtask
  task automatic t_debounce;
    int n;
    i_host_model.pin(1'b0);
    for (n = 0; n < 3 * DEB && active !== 1'b1; n++) @(negedge clk);
    chk("debounce", 8'(n), 8'(DEB));
    if (active !== 1'b1) wrap_up();
  endtask
  task automatic t_defaults;
    logic [7:0] adr [14] = '{ADDR_IDENTITY, ADDR_CTRL_ONE, ADDR_LATCHES,
      ADDR_MASK, ADDR_SRC_THR, ADDR_SRC_TMR, ADDR_CTRL_TWO, ADDR_PASS_FET,
      ADDR_ACC_THR, ADDR_RESULT, ADDR_FM_CUR, ADDR_FM_HI, ADDR_FM_LO, 8'h05};
    // the pin going low has latched its own event bit
    logic [7:0] exp [14] = '{ID_VAL, 8'h6a, 8'h01, 8'hff, 8'h03, 8'h13,
      8'h0c, 8'h00, 8'h6e, 8'h00, 8'h02, 8'haf, 8'h82, 8'h00};
    i_host_model.wr(ADDR_IDENTITY, 8'h00);
    i_host_model.wr(8'h05, 8'h55);
    foreach (adr[k]) rc(adr[k], exp[k]);
  endtask
  task automatic t_status;
    logic [7:0] d;
    i_host_model.rd(ADDR_LATCHES, d);
    i_host_model.wr(ADDR_CTRL_ONE, 8'h60);
    @(negedge clk);
    analog = '{bias_present: 1'b1, zero_cross_seen: 1'b1,
      period_timer_expired: 1'b1, id_overvoltage: 1'b1, default: '0};
    wait_n(2);
    rc(ADDR_STATUS, 8'hd3);
    rc(ADDR_LATCHES, 8'hd2);
    rc(ADDR_LATCHES, 8'h00);
    i_host_model.wr(ADDR_CTRL_ONE, 8'h42);
    rc(ADDR_STATUS, 8'h13);
    i_host_model.wr(ADDR_CTRL_ONE, 8'h43);
    chk("sleep", {6'h00, shut, active}, 8'h02);
    i_host_model.wr(ADDR_CTRL_ONE, 8'h42);
    // leaving sleep, the levels still present show up as fresh events
    rc(ADDR_LATCHES, 8'h13);
  endtask
  task automatic conv(input logic [7:0] v);
    @(negedge clk);
    analog.conv_done = 1'b1;
    analog.conv_result = v;
    @(negedge clk);
    analog.conv_done = 1'b0;
    wait_n(2);
  endtask
  task automatic t_conv_int;
    conv(8'h5b);
    chk("int masked", {7'h00, int_oe}, 8'h00);
    rc(ADDR_RESULT, 8'h5b);
    rc(ADDR_STATUS, 8'h33);
    rc(ADDR_STATUS, 8'h13);
    rc(ADDR_LATCHES, 8'h20);
    i_host_model.wr(ADDR_MASK, 8'hdf);
    conv(8'ha4);
    chk("int raised", {7'h00, int_oe}, 8'h01);
    rc(ADDR_LATCHES, 8'h20);
    chk("int freed", {7'h00, int_oe}, 8'h00);
  endtask
  task automatic t_pass_fet;
    i_host_model.wr(ADDR_PASS_FET, 8'h03);
    wait_n(1);
    chk("fet manual on", {7'h00, pf_oe}, 8'h01);
    i_host_model.wr(ADDR_PASS_FET, 8'h01);
    wait_n(1);
    chk("fet manual off", {7'h00, pf_oe}, 8'h00);
    i_host_model.wr(ADDR_CTRL_ONE, 8'h40);
    analog.fm_ready = 1'b1;
    wait_n(2);
    i_host_model.wr(ADDR_PASS_FET, 8'h00);
    wait_n(1);
    chk("fet auto on", {7'h00, pf_oe}, 8'h01);
    rc(ADDR_PASS_FET, 8'h08);
  endtask
  task automatic t_shutdown;
    i_host_model.pin(1'b1);
    wait_n(2);
    rc(ADDR_CTRL_ONE, RST_CTRL_ONE);
    rc(ADDR_MASK, RST_MASK);
    chk("fet off", {7'h00, pf_oe}, 8'h00);
  endtask
  initial begin
    wait_n(4);
    rst = 1'b0;
    t_shut_hold();
    t_debounce();
    t_defaults();
    t_status();
    t_conv_int();
    t_pass_fet();
    t_shutdown();
    wrap_up();
  end
endmodule
